// [txsb_fifo.v]
// parameterised valid/ready fifo holding queued symbol slot numbers
`timescale 1ns/1ps
`default_nettype none

module txsb_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             clk_sys_i,
  input  wire             nrst_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  // fill level
  output wire [AW:0]      level_o
);

  localparam [AW:0] FULL_LVL = DEPTH[AW:0];

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire push = in_valid_i && (count != FULL_LVL);
  wire pop  = out_ready_i && (count != {(AW+1){1'b0}});

  assign in_ready_o  = (count != FULL_LVL);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign level_o     = count;

  // ==========================================================================
  // pointers and storage
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr      <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

endmodule

`default_nettype wire

// [txsb_regs.vh]
// register map, field positions and reset values of the transmit symbol shaper
`ifndef TXSB_REGS_VH
`define TXSB_REGS_VH

// ==========================================================================
// register offsets
`define TXSB_ADDR_PAT0_HI     8'h4d
`define TXSB_ADDR_PAT0_LO     8'h4e
`define TXSB_ADDR_PAT1_HI     8'h4f
`define TXSB_ADDR_PAT1_LO     8'h50
`define TXSB_ADDR_PAT2        8'h51
`define TXSB_ADDR_PAT3        8'h52
`define TXSB_ADDR_LEN01       8'h53
`define TXSB_ADDR_LEN23       8'h54
`define TXSB_ADDR_BURST_CTRL  8'h55
`define TXSB_ADDR_MOD01       8'h56
`define TXSB_ADDR_STATUS      8'h5e
`define TXSB_ADDR_BURST_LEN   8'h5f

// ==========================================================================
// writable bit masks (reserved bits read zero)
`define TXSB_MASK_LEN23       8'h77
`define TXSB_MASK_BURST_CTRL  8'h77
`define TXSB_MASK_MOD01       8'h7f

// ==========================================================================
// field positions
`define TXSB_LEN3_MSB         6
`define TXSB_LEN3_LSB         4
`define TXSB_LEN2_MSB         2
`define TXSB_LEN2_LSB         0
`define TXSB_LEN1_MSB         7
`define TXSB_LEN1_LSB         4
`define TXSB_LEN0_MSB         3
`define TXSB_LEN0_LSB         0
`define TXSB_S1_POL_BIT       6
`define TXSB_S1_ALONE_BIT     5
`define TXSB_S1_EN_BIT        4
`define TXSB_S0_POL_BIT       2
`define TXSB_S0_ALONE_BIT     1
`define TXSB_S0_EN_BIT        0
`define TXSB_MILLER_BIT       6
`define TXSB_PULSE_MSB        5
`define TXSB_PULSE_LSB        4
`define TXSB_INV_BIT          3
`define TXSB_ENV_MSB          2
`define TXSB_ENV_LSB          0

// ==========================================================================
// reset values
`define TXSB_RST_REG8         8'h00
`define TXSB_RST_REG16        16'h0000

// ==========================================================================
// pulse kinds and envelope kinds
`define TXSB_PULSE_NONE       2'h0
`define TXSB_PULSE_START      2'h1
`define TXSB_PULSE_HALF       2'h2
`define TXSB_PULSE_3Q         2'h3
`define TXSB_ENV_DIRECT       3'h0
`define TXSB_ENV_MAN          3'h1
`define TXSB_ENV_MAN_SC       3'h2
`define TXSB_ENV_BPSK         3'h3
`define TXSB_ENV_RZ_A         3'h4
`define TXSB_ENV_RZ_B         3'h5

`endif

// [txsb_rf_model.sv]
// transmitter driver model: records the last 64 clock samples of one symbol
`timescale 1ns/1ps
`default_nettype none
module txsb_rf_model (
  // clock
  input  wire logic        clk_sys_i,
  // shaped stream
  input  wire logic        tx_data_i,
  input  wire logic        tx_active_i,
  // last symbol, newest sample in bit 0
  output var  logic [63:0] cap_o,
  output var  logic [7:0]  cnt_o
);
  logic act_q;

  // a new symbol restarts the record, so stale samples never leak in
  always @(posedge clk_sys_i)
  begin
    act_q <= tx_active_i;
    if (tx_active_i)
    begin
      cap_o <= act_q ? {cap_o[62:0], tx_data_i} : {63'h0, tx_data_i};
      cnt_o <= act_q ? cnt_o + 8'h01 : 8'h01;
    end
  end
endmodule
`default_nettype wire

// [txsb_shaper.v]
// transmit symbol sequencer: burst, pattern, pulse and envelope shaping
// ==========================================================================
// How it works
// - slot three sends length field bits 6..4 plus one pattern bits
// - slot two sends length field bits 2..0 plus one pattern bits
// - control bit 6 sets slot one burst polarity, zero or one
// - control bit 5 makes slot one, when bit 4 is set, a burst with no pattern
// - control bit 4 enables slot one burst of the burst length
// - control bit 2 sets slot zero burst polarity, zero or one
// - control bit 1 makes slot zero, when bit 0 is set, a burst with no pattern
// - control bit 0 enables slot zero burst of the burst length
// - modulation bit 6 applies modified Miller pulses to slots zero and one
// - pulse kind bits 5..4: none, bit start, second half, third quarter
// - modulation bit 3 inverts slot zero and one output
// - slot zero/one stream combines with envelope chosen by bits 2..0 when pulse kind is none and Miller is off
// - envelope 0 direct, 1 Manchester, 2 Manchester subcarrier, 3 BPSK
// - envelope 4 and 5 return-to-zero half-bit pulse; 6 and 7 reserved
// - slots zero and one hold 16-bit patterns, slots two, three 8-bit
// - slot zero and one lengths are 4-bit count-minus-one fields
`timescale 1ns/1ps
`default_nettype none
`include "txsb_regs.vh"

module txsb_shaper #(
  parameter BIT_CYC    = 8,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       nrst_i,
  // register port
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  // symbol request stream
  input  wire       sym_valid_i,
  output reg        sym_ready_o,
  input  wire [1:0] sym_slot_i,
  // shaped stream to the transmitter driver
  output reg        tx_data_o,
  output reg        tx_active_o,
  output reg        sym_done_o
);

  // bit timing inside one bit period
  localparam PW = $clog2(BIT_CYC);
  localparam integer HALF_I = BIT_CYC / 2;
  localparam integer QUART_I = BIT_CYC / 4;
  localparam integer TQ_I = (3 * BIT_CYC) / 4;
  localparam integer LAST_I = BIT_CYC - 1;
  localparam [PW-1:0] HALF_PH = HALF_I[PW-1:0];
  localparam [PW-1:0] QUART_PH = QUART_I[PW-1:0];
  localparam [PW-1:0] TQ_PH = TQ_I[PW-1:0];
  localparam [PW-1:0] LAST_PH = LAST_I[PW-1:0];

  // sequencer states
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_BURST = 3'b010;
  localparam [2:0] ST_PATT  = 3'b100;

  // ==========================================================================
  // configuration registers
  reg [15:0] pattern_slot_zero;
  reg [15:0] pattern_slot_one;
  reg [7:0]  pattern_slot_two;
  reg [7:0]  pattern_slot_three;
  reg [7:0]  tx_symbol01_length;
  reg [7:0]  tx_symbol23_length;
  reg [7:0]  tx_symbol01_burst_control;
  reg [7:0]  tx_symbol01_modulation;
  reg [7:0]  low_pair_burst_length_reg;

  // sequencer state
  reg [2:0]    state;
  reg [1:0]    slot;
  reg [7:0]    bit_cnt;
  reg [PW-1:0] phase;
  reg          prev_bit;

  // fifo hookup
  wire         q_valid;
  wire [1:0]   q_slot;
  wire [FIFO_AW:0] q_level;
  wire         fifo_in_ready;
  wire         q_pop = state[0] & q_valid;

  // field views
  wire [3:0] slot_zero_bit_count  = tx_symbol01_length[`TXSB_LEN0_MSB:`TXSB_LEN0_LSB];
  wire [3:0] slot_one_bit_count   = tx_symbol01_length[`TXSB_LEN1_MSB:`TXSB_LEN1_LSB];
  wire [2:0] slot_two_bit_count   = tx_symbol23_length[`TXSB_LEN2_MSB:`TXSB_LEN2_LSB];
  wire [2:0] slot_three_bit_count = tx_symbol23_length[`TXSB_LEN3_MSB:`TXSB_LEN3_LSB];
  wire slot_zero_burst_enable   = tx_symbol01_burst_control[`TXSB_S0_EN_BIT];
  wire slot_zero_burst_alone    = tx_symbol01_burst_control[`TXSB_S0_ALONE_BIT];
  wire slot_zero_burst_polarity = tx_symbol01_burst_control[`TXSB_S0_POL_BIT];
  wire slot_one_burst_enable    = tx_symbol01_burst_control[`TXSB_S1_EN_BIT];
  wire slot_one_burst_alone     = tx_symbol01_burst_control[`TXSB_S1_ALONE_BIT];
  wire slot_one_burst_polarity  = tx_symbol01_burst_control[`TXSB_S1_POL_BIT];
  wire       low_pair_miller_enable = tx_symbol01_modulation[`TXSB_MILLER_BIT];
  wire [1:0] low_pair_pulse_kind    = tx_symbol01_modulation[`TXSB_PULSE_MSB:`TXSB_PULSE_LSB];
  wire       low_pair_invert        = tx_symbol01_modulation[`TXSB_INV_BIT];
  wire [2:0] low_pair_envelope_kind = tx_symbol01_modulation[`TXSB_ENV_MSB:`TXSB_ENV_LSB];

  // ==========================================================================
  // request fifo; the sequencer drains one slot number per symbol
  txsb_fifo #(
    .WIDTH (2),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (sym_valid_i),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (sym_slot_i),
    .out_valid_o (q_valid),
    .out_ready_i (q_pop),
    .out_data_o  (q_slot),
    .level_o     (q_level)
  );

  // ==========================================================================
  // register writes; masks keep reserved bits at zero
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      pattern_slot_zero         <= `TXSB_RST_REG16;
      pattern_slot_one          <= `TXSB_RST_REG16;
      pattern_slot_two          <= `TXSB_RST_REG8;
      pattern_slot_three        <= `TXSB_RST_REG8;
      tx_symbol01_length        <= `TXSB_RST_REG8;
      tx_symbol23_length        <= `TXSB_RST_REG8;
      tx_symbol01_burst_control <= `TXSB_RST_REG8;
      tx_symbol01_modulation    <= `TXSB_RST_REG8;
      low_pair_burst_length_reg <= `TXSB_RST_REG8;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `TXSB_ADDR_PAT0_HI:    pattern_slot_zero[15:8] <= reg_wdata_i;
        `TXSB_ADDR_PAT0_LO:    pattern_slot_zero[7:0] <= reg_wdata_i;
        `TXSB_ADDR_PAT1_HI:    pattern_slot_one[15:8] <= reg_wdata_i;
        `TXSB_ADDR_PAT1_LO:    pattern_slot_one[7:0] <= reg_wdata_i;
        `TXSB_ADDR_PAT2:       pattern_slot_two <= reg_wdata_i;
        `TXSB_ADDR_PAT3:       pattern_slot_three <= reg_wdata_i;
        `TXSB_ADDR_LEN01:      tx_symbol01_length <= reg_wdata_i;
        `TXSB_ADDR_LEN23:      tx_symbol23_length <= reg_wdata_i & `TXSB_MASK_LEN23;
        `TXSB_ADDR_BURST_CTRL:
          tx_symbol01_burst_control <= reg_wdata_i & `TXSB_MASK_BURST_CTRL;
        `TXSB_ADDR_MOD01:      tx_symbol01_modulation <= reg_wdata_i & `TXSB_MASK_MOD01;
        `TXSB_ADDR_BURST_LEN:  low_pair_burst_length_reg <= reg_wdata_i;
        default:               ;
      endcase
    end
  end

  // ==========================================================================
  // register reads, one cycle after the strobe; unmapped reads give zero
  reg [7:0] next_rdata;

  always @*
  begin
    case (reg_addr_i)
      `TXSB_ADDR_PAT0_HI:    next_rdata = pattern_slot_zero[15:8];
      `TXSB_ADDR_PAT0_LO:    next_rdata = pattern_slot_zero[7:0];
      `TXSB_ADDR_PAT1_HI:    next_rdata = pattern_slot_one[15:8];
      `TXSB_ADDR_PAT1_LO:    next_rdata = pattern_slot_one[7:0];
      `TXSB_ADDR_PAT2:       next_rdata = pattern_slot_two;
      `TXSB_ADDR_PAT3:       next_rdata = pattern_slot_three;
      `TXSB_ADDR_LEN01:      next_rdata = tx_symbol01_length;
      `TXSB_ADDR_LEN23:      next_rdata = tx_symbol23_length;
      `TXSB_ADDR_BURST_CTRL: next_rdata = tx_symbol01_burst_control;
      `TXSB_ADDR_MOD01:      next_rdata = tx_symbol01_modulation;
      `TXSB_ADDR_BURST_LEN:  next_rdata = low_pair_burst_length_reg;
      `TXSB_ADDR_STATUS:
        next_rdata = {~state[0], fifo_in_ready, 2'h0, q_level[3:0]};
      default:               next_rdata = 8'h00;
    endcase
  end

  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
  end

  // ==========================================================================
  // per-slot decode of what a symbol is made of
  reg       cur_burst_en;
  reg       cur_alone;
  reg       cur_pol;
  reg [7:0] cur_len;

  always @*
  begin
    cur_burst_en = 1'b0;
    cur_alone    = 1'b0;
    cur_pol      = 1'b0;
    cur_len      = 8'h00;
    case (slot)
      2'h0:
      begin
        cur_burst_en = slot_zero_burst_enable;
        cur_alone    = slot_zero_burst_alone;
        cur_pol      = slot_zero_burst_polarity;
        cur_len      = {4'h0, slot_zero_bit_count};
      end
      2'h1:
      begin
        cur_burst_en = slot_one_burst_enable;
        cur_alone    = slot_one_burst_alone;
        cur_pol      = slot_one_burst_polarity;
        cur_len      = {4'h0, slot_one_bit_count};
      end
      2'h2:    cur_len = {5'h00, slot_two_bit_count};
      default: cur_len = {5'h00, slot_three_bit_count};
    endcase
  end

  // current raw bit, patterns sent most significant valid bit first
  reg raw_bit;

  always @*
  begin
    raw_bit = 1'b0;
    if (state[1])
      raw_bit = cur_pol;
    else if (state[2])
    begin
      case (slot)
        2'h0:    raw_bit = pattern_slot_zero[bit_cnt[3:0]];
        2'h1:    raw_bit = pattern_slot_one[bit_cnt[3:0]];
        2'h2:    raw_bit = pattern_slot_two[bit_cnt[2:0]];
        default: raw_bit = pattern_slot_three[bit_cnt[2:0]];
      endcase
    end
  end

  // ==========================================================================
  // pulse and envelope shaping for slots zero and one
  reg [PW-1:0] pulse_start;
  reg          pulse_on;
  reg          shaped;
  reg          next_tx;
  wire         second_half = (phase >= HALF_PH);
  wire         subcarrier  = phase[0];
  wire [PW-1:0] ph_off     = phase - pulse_start;

  always @*
  begin
    pulse_start = {PW{1'b0}};
    pulse_on    = 1'b1;
    if (low_pair_miller_enable)
    begin
      // a zero after a one carries no pulse; a one pulses mid-bit
      if (raw_bit)
        pulse_start = HALF_PH;
      else if (prev_bit)
        pulse_on = 1'b0;
    end
    else
    begin
      case (low_pair_pulse_kind)
        `TXSB_PULSE_HALF: pulse_start = HALF_PH;
        `TXSB_PULSE_3Q:   pulse_start = TQ_PH;
        default:          pulse_start = {PW{1'b0}};
      endcase
      pulse_on = raw_bit;
    end
  end

  always @*
  begin
    shaped = raw_bit;
    if (low_pair_pulse_kind != `TXSB_PULSE_NONE || low_pair_miller_enable)
      shaped = pulse_on && (phase >= pulse_start) && (ph_off < QUART_PH);
    else
    begin
      case (low_pair_envelope_kind)
        `TXSB_ENV_DIRECT: shaped = raw_bit;
        `TXSB_ENV_MAN:    shaped = raw_bit ^ second_half;
        `TXSB_ENV_MAN_SC: shaped = (raw_bit ^ second_half) & subcarrier;
        `TXSB_ENV_BPSK:   shaped = raw_bit ^ subcarrier;
        // both return-to-zero codes place the pulse in the second half
        `TXSB_ENV_RZ_A:   shaped = raw_bit & second_half;
        `TXSB_ENV_RZ_B:   shaped = raw_bit & second_half;
        default:          shaped = raw_bit;
      endcase
    end
    if (state[0])
      next_tx = 1'b0;
    else if (slot[1])
      next_tx = raw_bit;
    else
      next_tx = shaped ^ low_pair_invert;
  end

  // ==========================================================================
  // symbol sequencer
  wire bit_end = (phase == LAST_PH);

  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      state      <= ST_IDLE;
      slot       <= 2'h0;
      bit_cnt    <= 8'h00;
      phase      <= {PW{1'b0}};
      prev_bit   <= 1'b0;
      sym_done_o <= 1'b0;
    end
    else
    begin
      sym_done_o <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          phase <= {PW{1'b0}};
          if (q_valid)
          begin
            slot <= q_slot;
            // burst settings only exist for slots zero and one
            if (!q_slot[1] && (q_slot[0] ? slot_one_burst_enable : slot_zero_burst_enable))
            begin
              state   <= ST_BURST;
              bit_cnt <= low_pair_burst_length_reg;
            end
            else
            begin
              state <= ST_PATT;
              case (q_slot)
                2'h0:    bit_cnt <= {4'h0, slot_zero_bit_count};
                2'h1:    bit_cnt <= {4'h0, slot_one_bit_count};
                2'h2:    bit_cnt <= {5'h00, slot_two_bit_count};
                default: bit_cnt <= {5'h00, slot_three_bit_count};
              endcase
            end
          end
          else
            prev_bit <= 1'b0;
        end
        ST_BURST:
        begin
          phase <= bit_end ? {PW{1'b0}} : phase + 1'b1;
          if (bit_end)
          begin
            prev_bit <= raw_bit;
            if (bit_cnt != 8'h00)
              bit_cnt <= bit_cnt - 1'b1;
            else if (cur_alone && cur_burst_en)
            begin
              state      <= ST_IDLE;
              sym_done_o <= 1'b1;
            end
            else
            begin
              state   <= ST_PATT;
              bit_cnt <= cur_len;
            end
          end
        end
        ST_PATT:
        begin
          phase <= bit_end ? {PW{1'b0}} : phase + 1'b1;
          if (bit_end)
          begin
            prev_bit <= raw_bit;
            if (bit_cnt != 8'h00)
              bit_cnt <= bit_cnt - 1'b1;
            else
            begin
              state      <= ST_IDLE;
              sym_done_o <= 1'b1;
            end
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // registered outputs
  always @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      tx_data_o   <= 1'b0;
      tx_active_o <= 1'b0;
      sym_ready_o <= 1'b0;
    end
    else
    begin
      tx_data_o   <= next_tx;
      tx_active_o <= ~state[0];
      // registered ready is one cycle late, so it looks one entry ahead and drops as the last free entry fills
      sym_ready_o <= (q_level < FIFO_DEPTH[FIFO_AW:0] - 1'b1) ||
                     (q_level == FIFO_DEPTH[FIFO_AW:0] - 1'b1 && !sym_valid_i);
    end
  end

endmodule

`default_nettype wire

// [txsb_shaper_assertions.sv]
// port checker for the transmit symbol shaper
`timescale 1ns/1ps
`default_nettype none
module txsb_shaper_assertions (
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // shaped stream
  input wire logic       tx_data_o,
  input wire logic       tx_active_o,
  input wire logic       sym_done_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // ====
  // register port
  sequence s_wr_ctrl;
    reg_wr_i && reg_addr_i == 8'h55 && reg_wdata_i == 8'hff;
  endsequence
  sequence s_rd_ctrl;
    reg_rd_i && !reg_wr_i && reg_addr_i == 8'h55;
  endsequence
  a_ctrl_write_back: assert property (s_wr_ctrl ##1 !reg_wr_i ##1 s_rd_ctrl |=>
    reg_rdata_o == 8'h77) else $error("control register readback wrong");
  a_len_reserved_zero: assert property (reg_rd_i && reg_addr_i == 8'h54 |=>
    reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0) else $error("length reserved bit set");
  a_mod_reserved_zero: assert property (reg_rd_i && reg_addr_i == 8'h56 |=>
    reg_rdata_o[7] == 1'b0) else $error("modulation reserved bit set");
  a_unmapped_reads_zero: assert property (reg_rd_i && reg_addr_i == 8'h60 |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  // ====
  // shaped stream
  a_idle_line_low: assert property (!tx_active_o |-> !tx_data_o)
    else $error("data high while idle");
  a_done_ends_symbol: assert property (sym_done_o |=> !tx_active_o && !sym_done_o)
    else $error("symbol continues after done");
  a_end_needs_done: assert property ($fell(tx_active_o) |-> $past(sym_done_o))
    else $error("symbol ended without done");
  a_one_bit_min: assert property ($rose(tx_active_o) |-> tx_active_o [*4])
    else $error("symbol shorter than one bit");
endmodule

bind txsb_shaper txsb_shaper_assertions txsb_shaper_assertions_i (
  .clk_sys_i   (clk_sys_i),
  .nrst_i      (nrst_i),
  .reg_addr_i  (reg_addr_i),
  .reg_wdata_i (reg_wdata_i),
  .reg_wr_i    (reg_wr_i),
  .reg_rd_i    (reg_rd_i),
  .reg_rdata_o (reg_rdata_o),
  .tx_data_o   (tx_data_o),
  .tx_active_o (tx_active_o),
  .sym_done_o  (sym_done_o)
);
`default_nettype wire

// [txsb_shaper_test.sv]
// self-checking bench for the transmit symbol shaper
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module txsb_shaper_test;
  logic        clk_sys_i   = 1'b0;
  logic        nrst_i      = 1'b0;
  logic [7:0]  reg_addr_i  = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [7:0]  reg_rdata_o;
  logic        sym_valid_i = 1'b0;
  logic        sym_ready_o;
  logic [1:0]  sym_slot_i  = 2'h0;
  logic        tx_data_o;
  logic        tx_active_o;
  logic        sym_done_o;
  logic [63:0] cap_o;
  logic [7:0]  cnt_o;
  int          n_mismatch  = 0;
  int          check_count = 0;
  int          cyc         = 0;
  int          done_cnt    = 0;

  // four clocks a bit keeps every quarter one cycle long
  txsb_shaper #(.BIT_CYC(4)) txsb_shaper_i (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sym_valid_i(sym_valid_i), .sym_ready_o(sym_ready_o),
    .sym_slot_i(sym_slot_i), .tx_data_o(tx_data_o), .tx_active_o(tx_active_o),
    .sym_done_o(sym_done_o));
  txsb_rf_model txsb_rf_model_i (.clk_sys_i(clk_sys_i), .tx_data_i(tx_data_o),
    .tx_active_i(tx_active_o), .cap_o(cap_o), .cnt_o(cnt_o));

  initial
  begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // ====
  // helpers
  task automatic wrap_up();
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (sym_done_o) done_cnt++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    d = reg_rdata_o;
  endtask
  // expected samples: bits sent msb first, four quarters each
  function automatic logic [63:0] expand(input logic [15:0] b, input int n,
                                         input logic [7:0] m, input bit shp);
    logic [63:0] v;
    bit          prv;
    bit          o;
    v   = 64'h0;
    prv = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (!shp) o = b[i];
        else if (m[6]) o = b[i] ? (k == 2) : (!prv && k == 0);
        else if (m[5:4] != 2'h0) o = b[i] && (k == (m[5:4] == 2'h1 ? 0 : m[5:4] == 2'h2 ? 2 : 3));
        else
          case (m[2:0])
            3'h1: o = b[i] ^ (k >= 2);
            3'h2: o = (b[i] ^ (k >= 2)) & k[0];
            3'h3: o = b[i] ^ k[0];
            3'h4, 3'h5: o = b[i] & (k >= 2);
            default: o = b[i];
          endcase
        if (shp) o ^= m[3];
        v = {v[62:0], o};
      end
      prv = b[i];
    end
    return v;
  endfunction
  task automatic send(input logic [1:0] s, input logic [15:0] b, input int n,
                      input logic [7:0] m, input bit shp);
    int w;
    @(posedge clk_sys_i);
    sym_valid_i <= 1'b1;
    sym_slot_i  <= s;
    @(negedge clk_sys_i);
    for (w = 0; w < 50 && !sym_ready_o; w++) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    sym_valid_i <= 1'b0;
    for (w = 0; w < 200 && !sym_done_o; w++) @(negedge clk_sys_i);
    repeat (2) @(posedge clk_sys_i);
    `CHK(cnt_o, 8'(n * 4))
    `CHK(cap_o, expand(b, n, m, shp))
  endtask
  // ====
  // scenarios
  task automatic reg_check();
    logic [7:0] a [3] = '{8'h54, 8'h55, 8'h56};
    logic [7:0] k [3] = '{8'h77, 8'h77, 8'h7f};
    logic [7:0] d;
    for (int i = 0; i < 3; i++)
    begin
      rd(a[i], d);
      `CHK(d, 8'h00)
      wr(a[i], 8'hff);
      rd(a[i], d);
      `CHK(d, k[i])
    end
    wr(8'h60, 8'hff);
    rd(8'h60, d);
    `CHK(d, 8'h00)
  endtask
  task automatic slot_len_check();
    wr(8'h51, 8'ha5);
    wr(8'h52, 8'h6c);
    wr(8'h54, 8'h52);
    send(2'd2, 16'h0005, 3, 8'h00, 1'b0);
    send(2'd3, 16'h002c, 6, 8'h00, 1'b0);
    // shaping set up here must not touch slots two and three
    wr(8'h56, 8'h0b);
    wr(8'h54, 8'h07);
    send(2'd2, 16'h00a5, 8, 8'h00, 1'b0);
    send(2'd3, 16'h0000, 1, 8'h00, 1'b0);
  endtask
  task automatic burst_check();
    wr(8'h56, 8'h00);
    wr(8'h4d, 8'ha5);
    wr(8'h4e, 8'h0b);
    wr(8'h4f, 8'h80);
    wr(8'h50, 8'h02);
    wr(8'h53, 8'h0f);
    wr(8'h55, 8'h00);
    send(2'd0, 16'ha50b, 16, 8'h00, 1'b1);
    wr(8'h53, 8'h13);
    wr(8'h5f, 8'h01);
    wr(8'h55, 8'h05);
    send(2'd0, 16'h003b, 6, 8'h00, 1'b1);
    wr(8'h55, 8'h07);
    send(2'd0, 16'h0003, 2, 8'h00, 1'b1);
    wr(8'h55, 8'h11);
    send(2'd1, 16'h0002, 4, 8'h00, 1'b1);
    wr(8'h55, 8'h70);
    send(2'd1, 16'h0003, 2, 8'h00, 1'b1);
    wr(8'h55, 8'h20);
    send(2'd1, 16'h0002, 2, 8'h00, 1'b1);
    wr(8'h55, 8'h00);
  endtask
  task automatic shape_check();
    logic [7:0] m [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                           8'h0b, 8'h10, 8'h20, 8'h30, 8'h50};
    foreach (m[i])
    begin
      wr(8'h56, m[i]);
      send(2'd0, 16'h000b, 4, m[i], 1'b1);
    end
  endtask
  task automatic fifo_check();
    int         acc;
    int         w;
    logic [7:0] d;
    wr(8'h54, 8'h70);
    done_cnt = 0;
    acc      = 0;
    @(posedge clk_sys_i);
    sym_valid_i <= 1'b1;
    sym_slot_i  <= 2'd3;
    for (w = 0; w < 40; w++)
    begin
      @(negedge clk_sys_i);
      if (sym_ready_o) acc++;
      else if (acc > 0) break;
      @(posedge clk_sys_i);
    end
    `CHK(sym_ready_o, 1'b0)
    @(posedge clk_sys_i);
    sym_valid_i <= 1'b0;
    `CHK(acc, 9)
    rd(8'h5e, d);
    `CHK(d, 8'h88)
    for (w = 0; w < 3000 && done_cnt != acc; w++) @(posedge clk_sys_i);
    `CHK(done_cnt, acc)
    rd(8'h5e, d);
    `CHK(d, 8'h40)
  endtask

  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    reg_check();
    slot_len_check();
    burst_check();
    shape_check();
    fifo_check();
    wrap_up();
  end
endmodule
`default_nettype wire
